// ---- design/adcms_regs.vh ----
// Behaviour
// R01: After reset run normal mode, modulator tick every sixteen system clocks.
// R02: Three-bit rate select picks conversion length; rates scale with system clock.
// R03: Duty-cycle mode converts once then idles three conversion periods.
// R04: Turbo mode ticks the modulator every eight system clocks, doubling rates.
// R05: Sleep command lets a running conversion finish before powering down.
// R06: Power-down turns analog and excitation off, opens switch, keeps settings.
// R07: Begin-conversion wakes device, single or continuous per conversion mode bit.
// R08: Register write wakes device but starts only one conversion.
// R09: Serial link uses clock idle low, data sampled on second edge.
// R10: Chip select high resets the port, ignores clock, floats data out.
// R11: Master may hold chip select low permanently on an unshared bus.
// R12: Master keeps serial clock low whenever the port is idle.
// R13: Ready output falls on new result, rises on next serial clock rise.
// R14: Unread continuous results: ready pulses high two modulator periods before falling.
// R15: Dedicated ready output is always driven, chip select or not.
// R16: Serial input sampled on falling clock edges, never driven.
// R17: Data out shifts on rising serial clock edges.
// R18: With ready-on-dataout enabled, data out falls together with ready.
// R19: Incomplete command after 13955 or 27910 modulator periods resets the port.
// R20: Register commands complete only after all their data bytes.
// R21: Results are 16-bit two's complement words.
// R22: Begin-conversion is 0000100x, sleep is 0000001x, low bit ignored.
// R23: Conversion mode bit one selects continuous, needing begin-conversion to start.
// R24: Results shift out most significant bit first, two bytes.
// R25: A configuration field selects normal, duty-cycle or turbo mode.
`ifndef ADCMS_REGS_VH
`define ADCMS_REGS_VH

// Modulator dividers
`define ADCMS_DIV_NORMAL      4'd15
`define ADCMS_DIV_TURBO       4'd7

// Timeouts in modulator periods
`define ADCMS_TIMEOUT_NORMAL  15'd13955
`define ADCMS_TIMEOUT_TURBO   15'd27910

// Conversion length per rate code, code 0 in the low slice
`define ADCMS_CONV_PERIODS    {16'd256, 16'd256, 16'd400, 16'd800, 16'd1600, 16'd3200, 16'd6400, 16'd12800}

// Command bytes; reset, start and sleep with low bit masked, read and register commands by top nibble
`define ADCMS_CMD_RESET       7'h03
`define ADCMS_CMD_START       7'h04
`define ADCMS_CMD_SLEEP       7'h01
`define ADCMS_CMD_RDATA       4'h1
`define ADCMS_CMD_REG_READ_CMD        4'h2
`define ADCMS_CMD_REG_WRITE_CMD        4'h4

// Configuration bytes, byte 0 in the top slice
`define ADCMS_CFG_RESET       32'h00000000
`define ADCMS_RATE_MSB        23
`define ADCMS_RATE_LSB        21
`define ADCMS_MODE_MSB        20
`define ADCMS_MODE_LSB        19
`define ADCMS_CM_BIT          18
`define ADCMS_RDYM_BIT        1

// Operating mode codes
`define ADCMS_MODE_NORMAL     2'd0
`define ADCMS_MODE_DUTY       2'd1
`define ADCMS_MODE_TURBO      2'd2

// Idle periods in duty-cycle mode
`define ADCMS_DUTY_IDLE       2'd3

`endif

// ---- design/adcms_moddiv.v ----
`default_nettype none
module adcms_moddiv (
    // Clock and reset
    input  wire       clk,
    input  wire       reset,
    // Divide select
    input  wire [3:0] limit,
    // Modulator enable
    output reg        tick
);
    reg [3:0] cnt_q;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 4'h0;
            tick  <= 1'b0;
        end else if (cnt_q >= limit) begin
            cnt_q <= 4'h0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            tick  <= 1'b0;
        end
    end
endmodule // adcms_moddiv
`default_nettype wire

// ---- design/adcms_fifo.v ----
`default_nettype none
module adcms_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             clk,
    input  wire             reset,
    // Fill side
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output reg              in_ready,
    // Drain side
    output wire [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push = in_valid & in_ready;
    wire            pop  = out_valid & out_ready;
    wire [AW:0]     cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign out_data = mem[rd_q];

    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_q      <= {AW{1'b0}};
            rd_q      <= {AW{1'b0}};
            cnt_q     <= {(AW+1){1'b0}};
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            cnt_q     <= cnt_d;
            in_ready  <= (cnt_d != DEPTH);
            out_valid <= (cnt_d != {(AW+1){1'b0}});
        end
    end
endmodule // adcms_fifo
`default_nettype wire

// ---- design/adcms_core.v ----
`include "adcms_regs.vh"
`default_nettype none
module adcms_core #(
    parameter [14:0]  TIMEOUT_NORMAL = `ADCMS_TIMEOUT_NORMAL,
    parameter [14:0]  TIMEOUT_TURBO  = `ADCMS_TIMEOUT_TURBO,
    parameter [127:0] CONV_PERIODS   = `ADCMS_CONV_PERIODS,
    parameter         FIFO_DEPTH     = 32,
    parameter         FIFO_AW        = 5
) (
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Serial pins
    input  wire        cs_n,
    input  wire        sclk,
    input  wire        din,
    output reg         serial_out_with_ready,
    output reg         serial_out_oe,
    output reg         conversion_ready_n,
    // Filter result stream
    input  wire [15:0] filter_data,
    input  wire        filter_valid,
    output wire        filter_ready,
    // Analog control
    output reg         analog_enable,
    output reg         excitation_current_source,
    output reg         low_side_switch_closed,
    output reg         converting,
    // Configuration view
    output wire [2:0]  rate_select,
    output wire [1:0]  operating_mode,
    output wire        conversion_mode_bit,
    output wire        ready_on_dataout_enable
);
    localparam [1:0] PH_CMD  = 2'd0;
    localparam [1:0] PH_WR   = 2'd1;
    localparam [1:0] PH_RD   = 2'd2;
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_CONV = 2'd1;
    localparam [1:0] ST_DUTY = 2'd2;
    localparam [1:0] ST_SLP  = 2'd3;

    // Synchronisers
    reg        cs_s1_q;
    reg        cs_s2_q;
    reg        sclk_s1_q;
    reg        sclk_s2_q;
    reg        sclk_s3_q;
    reg        din_s1_q;
    reg        din_s2_q;
    // Serial state
    reg [1:0]  phase_q;
    reg [2:0]  bit_cnt_q;
    reg [7:0]  in_sh_q;
    reg [1:0]  byte_cnt_q;
    reg [1:0]  ptr_q;
    reg [31:0] out_sh_q;
    reg [14:0] to_cnt_q;
    reg [31:0] cfg_q;
    // Conversion state
    reg [1:0]  state_q;
    reg [15:0] conv_cnt_q;
    reg [1:0]  duty_n_q;
    reg        cont_q;
    reg        sleep_pend_q;
    reg [15:0] result_q;

    wire        mod_tick;
    wire [15:0] fifo_data;
    wire        fifo_valid;

    assign rate_select             = cfg_q[`ADCMS_RATE_MSB:`ADCMS_RATE_LSB];
    assign operating_mode          = cfg_q[`ADCMS_MODE_MSB:`ADCMS_MODE_LSB];
    assign conversion_mode_bit     = cfg_q[`ADCMS_CM_BIT];
    assign ready_on_dataout_enable = cfg_q[`ADCMS_RDYM_BIT];

    wire turbo = (operating_mode == `ADCMS_MODE_TURBO);
    wire duty  = (operating_mode == `ADCMS_MODE_DUTY);

    // Edges seen only while selected
    wire cs_active = ~cs_s2_q;
    wire sclk_rise = cs_active & sclk_s2_q & ~sclk_s3_q;   // see R09
    wire sclk_fall = cs_active & ~sclk_s2_q & sclk_s3_q;

    // Byte assembly
    wire       byte_done = sclk_fall & (bit_cnt_q == 3'd7);
    wire [7:0] rx_byte   = {in_sh_q[6:0], din_s2_q};
    wire       in_cmd    = (phase_q == PH_CMD);

    // Command decode
    wire cmd_byte  = byte_done & in_cmd;
    wire reset_ev  = cmd_byte & (rx_byte[7:1] == `ADCMS_CMD_RESET);
    wire start_ev  = cmd_byte & (rx_byte[7:1] == `ADCMS_CMD_START);   // see R22
    wire sleep_ev  = cmd_byte & (rx_byte[7:1] == `ADCMS_CMD_SLEEP);   // see R22
    wire rdata_ev  = cmd_byte & (rx_byte[7:4] == `ADCMS_CMD_RDATA);
    wire reg_read_cmd_ev   = cmd_byte & (rx_byte[7:4] == `ADCMS_CMD_REG_READ_CMD);
    wire reg_write_cmd_ev   = cmd_byte & (rx_byte[7:4] == `ADCMS_CMD_REG_WRITE_CMD);
    wire wr_byte   = byte_done & (phase_q == PH_WR);
    wire wr_done   = wr_byte & (byte_cnt_q == 2'd0);
    wire rd_done   = byte_done & (phase_q == PH_RD) & (byte_cnt_q == 2'd0);

    // Timeout
    wire        busy     = ~in_cmd | (bit_cnt_q != 3'd0);
    wire [14:0] to_limit = turbo ? TIMEOUT_TURBO : TIMEOUT_NORMAL;
    wire        to_hit   = busy & (to_cnt_q >= to_limit);
    wire        if_rst   = ~cs_active | to_hit;

    // Conversion timing
    wire [15:0] period    = CONV_PERIODS[{rate_select, 4'h0} +: 16];   // see R02
    wire [15:0] period_m2 = period - 16'h0002;
    // Partial first period after a command start is not counted
    wire        at_end    = (conv_cnt_q >= period);
    wire        conv_end  = (state_q == ST_CONV) & at_end & mod_tick & fifo_valid;
    wire        load_ok   = in_cmd & (bit_cnt_q == 3'd0) & ~sclk_rise;

    // Modulator clock
    adcms_moddiv u_moddiv (
        .clk   (clk),
        .reset (reset),
        .limit (turbo ? `ADCMS_DIV_TURBO : `ADCMS_DIV_NORMAL),   // see R01, R04
        .tick  (mod_tick)
    );

    // Result buffer
    adcms_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_data   (filter_data),
        .in_valid  (filter_valid),
        .in_ready  (filter_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (conv_end)
    );

    // Pin synchronisers
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            din_s1_q  <= 1'b0;
            din_s2_q  <= 1'b0;
        end else begin
            cs_s1_q   <= cs_n;
            cs_s2_q   <= cs_s1_q;
            sclk_s1_q <= sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            din_s1_q  <= din;
            din_s2_q  <= din_s1_q;
        end
    end

    // Serial port
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_q    <= PH_CMD;
            bit_cnt_q  <= 3'd0;
            in_sh_q    <= 8'h00;
            byte_cnt_q <= 2'd0;
            ptr_q      <= 2'd0;
            to_cnt_q   <= 15'd0;
        end else if (if_rst) begin
            phase_q    <= PH_CMD;   // see R10, R19
            bit_cnt_q  <= 3'd0;
            in_sh_q    <= 8'h00;
            byte_cnt_q <= 2'd0;
            to_cnt_q   <= 15'd0;
        end else begin
            if (sclk_fall) begin
                in_sh_q   <= rx_byte;   // see R16
                bit_cnt_q <= bit_cnt_q + 3'd1;
            end
            if (reg_read_cmd_ev | reg_write_cmd_ev) begin
                phase_q    <= reg_read_cmd_ev ? PH_RD : PH_WR;
                ptr_q      <= rx_byte[3:2];
                byte_cnt_q <= rx_byte[1:0];
            end else if (wr_done | rd_done) begin
                phase_q <= PH_CMD;
            end else if (byte_done & ~in_cmd) begin
                byte_cnt_q <= byte_cnt_q - 2'd1;
                ptr_q      <= ptr_q + 2'd1;
            end
            if (byte_done & (in_cmd ? ~(reg_read_cmd_ev | reg_write_cmd_ev) : (wr_done | rd_done))) begin
                to_cnt_q <= 15'd0;   // see R20
            end else if (busy & mod_tick) begin
                to_cnt_q <= to_cnt_q + 15'd1;   // see R19
            end
        end
    end

    // Configuration bytes
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_q <= `ADCMS_CFG_RESET;
        end else if (reset_ev) begin
            cfg_q <= `ADCMS_CFG_RESET;
        end else if (wr_byte) begin
            case (ptr_q)   // see R25
                2'd0:    cfg_q[31:24] <= rx_byte;
                2'd1:    cfg_q[23:16] <= rx_byte;
                2'd2:    cfg_q[15:8]  <= rx_byte;
                default: cfg_q[7:0]   <= rx_byte;
            endcase
        end
    end

    // Conversion sequencer
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q      <= ST_CONV;
            conv_cnt_q   <= 16'h0000;
            duty_n_q     <= 2'd0;
            cont_q       <= 1'b0;
            sleep_pend_q <= 1'b0;
            result_q     <= 16'h0000;
        end else if (reset_ev) begin
            state_q      <= ST_CONV;
            conv_cnt_q   <= 16'h0000;
            cont_q       <= 1'b0;
            sleep_pend_q <= 1'b0;
        end else if (start_ev) begin
            state_q      <= ST_CONV;   // see R07
            conv_cnt_q   <= 16'h0000;
            cont_q       <= conversion_mode_bit;   // see R23
            sleep_pend_q <= 1'b0;
        end else if (wr_done) begin
            state_q      <= ST_CONV;   // see R08
            conv_cnt_q   <= 16'h0000;
            cont_q       <= (state_q == ST_SLP) ? 1'b0 : cont_q;
            sleep_pend_q <= 1'b0;
        end else begin
            if (sleep_ev) begin
                if (state_q == ST_CONV) begin
                    sleep_pend_q <= 1'b1;   // see R05
                end else begin
                    state_q <= ST_SLP;
                end
            end
            case (state_q)
                ST_CONV: begin
                    if (conv_end) begin
                        result_q   <= fifo_data;   // see R21
                        conv_cnt_q <= 16'h0001;
                        duty_n_q   <= 2'd0;
                        if (sleep_pend_q | sleep_ev) begin
                            state_q      <= ST_SLP;   // see R05
                            sleep_pend_q <= 1'b0;
                        end else if (cont_q & conversion_mode_bit) begin
                            state_q <= duty ? ST_DUTY : ST_CONV;   // see R03
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end else if (mod_tick & ~at_end) begin
                        conv_cnt_q <= conv_cnt_q + 16'h0001;
                    end
                end
                ST_DUTY: begin
                    if (mod_tick) begin
                        if (at_end) begin
                            conv_cnt_q <= 16'h0001;
                            duty_n_q   <= duty_n_q + 2'd1;
                            if (duty_n_q == `ADCMS_DUTY_IDLE - 2'd1) begin
                                state_q <= ST_CONV;   // see R03
                            end
                        end else begin
                            conv_cnt_q <= conv_cnt_q + 16'h0001;
                        end
                    end
                end
                ST_IDLE: begin
                    conv_cnt_q <= 16'h0000;
                end
                default: begin
                    conv_cnt_q <= 16'h0000;
                end
            endcase
        end
    end

    // Output shifter and ready
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            out_sh_q              <= 32'h00000000;
            serial_out_with_ready <= 1'b1;
            serial_out_oe         <= 1'b0;
            conversion_ready_n    <= 1'b1;
        end else begin
            serial_out_oe <= cs_active;   // see R10
            if (conv_end) begin
                conversion_ready_n <= 1'b0;   // see R13, R15
            end else if (sclk_rise) begin
                conversion_ready_n <= 1'b1;   // see R13
            end else if ((state_q == ST_CONV) & cont_q & mod_tick &
                         (conv_cnt_q == period_m2)) begin
                conversion_ready_n <= 1'b1;   // see R14
            end
            if (conv_end & load_ok) begin
                out_sh_q <= {fifo_data, 16'h0000};   // see R24
                if (ready_on_dataout_enable) begin
                    serial_out_with_ready <= 1'b0;   // see R18
                end
            end else if (rdata_ev) begin
                out_sh_q <= {result_q, 16'h0000};
            end else if (reg_read_cmd_ev) begin
                out_sh_q <= cfg_q << {rx_byte[3:2], 3'b000};
            end else if (sclk_rise) begin
                serial_out_with_ready <= out_sh_q[31];   // see R17, R24
                out_sh_q              <= {out_sh_q[30:0], 1'b0};
            end
        end
    end

    // Analog power control
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            analog_enable             <= 1'b0;
            excitation_current_source <= 1'b0;
            low_side_switch_closed    <= 1'b0;
            converting                <= 1'b0;
        end else begin
            analog_enable             <= (state_q == ST_CONV);   // see R06
            excitation_current_source <= (state_q != ST_SLP);    // see R06
            low_side_switch_closed    <= (state_q != ST_SLP);    // see R06
            converting                <= (state_q == ST_CONV);
        end
    end
endmodule // adcms_core
`default_nettype wire

// ---- verification/adcms_ok_asserts.sv ----
`default_nettype none
module adcms_ok #(
    parameter [127:0] CONV_PERIODS = {8{16'h0100}}
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // Serial pins
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       serial_out_with_ready,
    input wire logic       serial_out_oe,
    input wire logic       conversion_ready_n,
    // Status
    input wire logic       analog_enable,
    input wire logic       excitation_current_source,
    input wire logic       converting,
    input wire logic [1:0] operating_mode,
    input wire logic       conversion_mode_bit,
    input wire logic       ready_on_dataout_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MinRun = 16 * CONV_PERIODS[127:112] - 8;
    localparam int MinTurbo = MinRun / 2 - 4;
    logic        sclk_q;
    logic [7:0]  age_q;
    logic [7:0]  hi_q;
    logic [31:0] run_q;
    // Cycles since sclk rise, ready high run, conversion run
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sclk_q <= 1'b0;
            age_q  <= 8'hff;
            hi_q   <= 8'hff;
            run_q  <= 32'h0;
        end else begin
            sclk_q <= sclk;
            age_q  <= (sclk && !sclk_q) ? 8'h0 : ((age_q == 8'hff) ? age_q : age_q + 8'h1);
            hi_q   <= !conversion_ready_n ? 8'h0 : ((hi_q == 8'hff) ? hi_q : hi_q + 8'h1);
            run_q  <= converting ? run_q + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    cs_float_a: assert property (cs_n [*6] |-> !serial_out_oe)
        else $error("data out driven while deselected");
    pd_enter_a: assert property ($fell(excitation_current_source) |-> !converting && !analog_enable)
        else $error("powered down during conversion");
    busy_analog_a: assert property (converting && $past(converting) |-> analog_enable)
        else $error("analog off while converting");
    run_norm_a: assert property ($fell(converting) && operating_mode != 2'd2 |-> run_q >= MinRun)
        else $error("normal conversion too short");
    run_turbo_a: assert property ($fell(converting) && operating_mode == 2'd2 |-> run_q >= MinTurbo && run_q < MinRun)
        else $error("turbo conversion length wrong");
    rdy_pulse_a: assert property ($fell(conversion_ready_n) && conversion_mode_bit && cs_n && hi_q < 8'd200 |-> hi_q >= 8'd30 && hi_q <= 8'd34)
        else $error("ready pulse width wrong");
    rdy_rise_a: assert property ($rose(conversion_ready_n) && !conversion_mode_bit |-> age_q <= 8'd10)
        else $error("ready rose without serial clock");
    dout_shift_a: assert property ($changed(serial_out_with_ready) && serial_out_oe && $past(serial_out_oe) && !$fell(conversion_ready_n) && !$rose(conversion_ready_n) |-> age_q <= 8'd8)
        else $error("data out moved off a rising edge");
    rdy_dout_a: assert property ($fell(conversion_ready_n) && ready_on_dataout_enable && !cs_n && serial_out_oe |-> !serial_out_with_ready)
        else $error("data out did not signal ready");
    cover property ($fell(conversion_ready_n) && cs_n);
    cover property ($fell(converting) && operating_mode == 2'd2);
    cover property ($fell(excitation_current_source));
endmodule // adcms_ok
`default_nettype wire

// ---- verification/adcms_master.sv ----
`default_nettype none
module adcms_master (
    // Serial pins
    output var logic cs_n,
    output var logic sclk,
    output var logic din,
    input wire logic sdo,
    input wire logic sdo_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q = 1'b0;
    // Released pin shows no stale level
    wire  pin = sdo_oe ? sdo : ~last_q;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din  = 1'b0;
    end
    task automatic sel(input logic v);
        cs_n = v;
        #200;
    endtask
    // Mode 1 frame, low n bits of tx, MSB first
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        #7;
        for (int i = n - 1; i >= 0; i--) begin
            din  = tx[i];
            sclk = 1'b1;
            #100;
            sclk = 1'b0;
            #100;
            rx     = {rx[30:0], pin};
            last_q = pin;
        end
    endtask
endmodule // adcms_master
`default_nettype wire

// ---- verification/test_adc_mode_and_serial_port.sv ----
`default_nettype none
module test_adc_mode_and_serial_port;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [23:0] cfg;
        logic [6:0]  view;
        int          cycles;
    } adcms_row_t;
    localparam [127:0] Conv = {8{16'h0010}};
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        f_valid = 1'b0;
    logic [15:0] f_data = 16'h0;
    wire         cs_n, sclk, din, sdo, sdo_oe, rdy_n, f_ready;
    wire         an_en, exc, lsw, conv, cm, rdym;
    wire  [2:0]  rate;
    wire  [1:0]  mode;
    logic [31:0] rx;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          n;
    int          nxt = 0;
    adcms_row_t  rows[4] = '{'{24'h000000, 7'h00, 256}, '{24'hb00000, 7'h58, 128},
                             '{24'h680002, 7'h35, 256}, '{24'he00002, 7'h71, 256}};
    adcms_core #(
        .TIMEOUT_NORMAL(15'h32), .TIMEOUT_TURBO(15'h32), .CONV_PERIODS(Conv)
    ) i_dut (
        .clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .din(din),
        .serial_out_with_ready(sdo), .serial_out_oe(sdo_oe), .conversion_ready_n(rdy_n),
        .filter_data(f_data), .filter_valid(f_valid), .filter_ready(f_ready),
        .analog_enable(an_en), .excitation_current_source(exc),
        .low_side_switch_closed(lsw), .converting(conv), .rate_select(rate),
        .operating_mode(mode), .conversion_mode_bit(cm), .ready_on_dataout_enable(rdym)
    );
    adcms_master i_mst (.cs_n(cs_n), .sclk(sclk), .din(din), .sdo(sdo), .sdo_oe(sdo_oe));
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    function automatic logic [15:0] word(input int k);
        return 16'h8001 + 16'(k) * 16'h1235;
    endfunction
    task automatic check_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_range(input string what, input int lo, input int hi, input int got);
        n_tests++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("Error %s expected %0d to %0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic wait_lvl(input logic v, output int cnt);
        cnt = 0;
        while (rdy_n !== v && cnt < 2000) begin
            @(negedge clk);
            cnt++;
        end
    endtask
    task automatic read_result();
        i_mst.xfer(32'h0, 16, rx);
        check_val("result", word(nxt), rx[15:0]);
        check_bit("ready after read", 1'b1, rdy_n);
        nxt++;
    endtask
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        check_bit("ready in reset", 1'b1, rdy_n);
        check_bit("oe in reset", 1'b0, sdo_oe);
        check_val("config in reset", 16'h0, {9'h0, rate, mode, cm, rdym});
        reset = 1'b0;
        for (int k = 0; k < 32; k++) begin
            f_valid = 1'b1;
            f_data  = word(k);
            @(negedge clk);
        end
        f_valid = 1'b0;
        @(negedge clk);
        check_bit("fifo full", 1'b0, f_ready);
        wait_lvl(1'b0, n);
        check_range("power-up conversion", 240, 290, n + 33);
        i_mst.sel(1'b0);
        read_result();
        check_bit("fifo space", 1'b1, f_ready);
        foreach (rows[r]) begin
            i_mst.xfer({8'h46, rows[r].cfg}, 32, rx);
            repeat (4) @(negedge clk);
            check_val("config", {9'h0, rows[r].view}, {9'h0, rate, mode, cm, rdym});
            wait_lvl(1'b0, n);
            check_range("conversion time", rows[r].cycles - 16, rows[r].cycles + 30, n + 8);
            if (rows[r].view[0])
                check_bit("ready on data out", 1'b0, sdo);
            read_result();
        end
        i_mst.xfer(32'h09, 8, rx);
        i_mst.xfer(32'h02, 8, rx);
        repeat (8) @(negedge clk);
        check_bit("busy after sleep", 1'b1, conv);
        wait_lvl(1'b0, n);
        repeat (8) @(negedge clk);
        check_val("powered down", 16'h0, {13'h0, exc, lsw, an_en});
        check_val("config kept", 16'h0071, {9'h0, rate, mode, cm, rdym});
        read_result();
        i_mst.xfer({8'h46, 24'he40002}, 32, rx);
        repeat (8) @(negedge clk);
        check_bit("woken", 1'b1, exc);
        wait_lvl(1'b0, n);
        read_result();
        repeat (600) @(negedge clk);
        check_bit("single only", 1'b0, conv);
        i_mst.xfer(32'h03, 8, rx);
        repeat (8) @(negedge clk);
        check_bit("asleep", 1'b0, exc);
        i_mst.xfer(32'h0, 4, rx);
        repeat (1000) @(negedge clk);
        i_mst.xfer(32'h08, 8, rx);
        repeat (8) @(negedge clk);
        check_bit("continuous start", 1'b1, conv);
        wait_lvl(1'b0, n);
        i_mst.sel(1'b1);
        check_bit("oe released", 1'b0, sdo_oe);
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, n);
        check_range("ready pulse", 30, 34, n);
        check_bit("ready driven", 1'b0, rdy_n);
        finish_test();
    end
endmodule // test_adc_mode_and_serial_port
bind adcms_core adcms_ok #(.CONV_PERIODS(CONV_PERIODS)) i_ok (
    .clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
    .serial_out_with_ready(serial_out_with_ready), .serial_out_oe(serial_out_oe),
    .conversion_ready_n(conversion_ready_n), .analog_enable(analog_enable),
    .excitation_current_source(excitation_current_source), .converting(converting),
    .operating_mode(operating_mode), .conversion_mode_bit(conversion_mode_bit),
    .ready_on_dataout_enable(ready_on_dataout_enable));
`default_nettype wire
